// File: core/pieg_flag_bank.sv
// one bank of sticky request flags, set by events, cleared by software
`timescale 1ns/1ps
`default_nettype none
module pieg_flag_bank #(
    parameter int          WIDTH    = 8,
    parameter logic [7:0]  RST_VAL  = 8'h00
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic [WIDTH-1:0] clr_i,
    output logic      [WIDTH-1:0] flags_o
);

    logic [WIDTH-1:0] flags_d;
    logic [WIDTH-1:0] flags_q;

    // set wins over a clear in the same cycle
    always_comb begin
        flags_d = (flags_q & ~clr_i) | set_i;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_q <= RST_VAL[WIDTH-1:0];
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_o = flags_q;

endmodule // pieg_flag_bank
`default_nettype wire

// File: core/pieg_gate.sv
// peripheral interrupt enable gate: enable registers, request flags, gated requests
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module pieg_gate (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic [pieg_pkg::ADDR_W-1:0] addr,
    input  wire logic [pieg_pkg::DATA_W-1:0] wdata,
    input  wire logic                        wr_stb,
    input  wire logic                        rd_stb,
    output logic      [pieg_pkg::DATA_W-1:0] rdata,
    input  wire logic                        parallel_port_rd_evt,
    input  wire logic                        parallel_port_wr_evt,
    input  wire logic [6:0]                  group_a_evt,
    input  wire logic [3:0]                  group_b_evt,
    output logic      [7:0]                  req_a,
    output logic      [3:0]                  req_b,
    output logic                             irq
);
    import pieg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register state

    logic [7:0] ena_a_d, ena_a_q;
    logic [7:0] ena_b_d, ena_b_q;
    logic [7:0] stat_d, stat_q;
    logic [7:0] mask_d, mask_q;
    logic [7:0] rdata_d, rdata_q;
    logic [7:0] req_a_d, req_a_q;
    logic [3:0] req_b_d, req_b_q;
    logic [7:0] req_a_prev_q;
    logic [3:0] req_b_prev_q;

    logic [7:0] flag_a, set_a, clr_a;
    logic [7:0] flag_b8, set_b, clr_b;
    logic       wr_ena_a, wr_ena_b, wr_flag_a, wr_flag_b, wr_stat, wr_mask;

    assign wr_ena_a  = wr_stb && (addr == ENA_A_OFS);
    assign wr_ena_b  = wr_stb && (addr == ENA_B_OFS);
    assign wr_flag_a = wr_stb && (addr == FLAG_A_OFS);
    assign wr_flag_b = wr_stb && (addr == FLAG_B_OFS);
    assign wr_stat   = wr_stb && (addr == IRQ_STAT_OFS);
    assign wr_mask   = wr_stb && (addr == IRQ_MASK_OFS);

    ////////////////////////////////////////////////////////////////////////////
    // request flags; software clears a flag by writing zero to it

    always_comb begin
        set_a                    = 8'h00;
        set_a[6:0]               = group_a_evt;
        set_a[BIT_PARALLEL_PORT] = parallel_port_rd_evt | parallel_port_wr_evt;
        set_b                    = {4'h0, group_b_evt};
        clr_a                    = wr_flag_a ? ~wdata : 8'h00;
        clr_b                    = wr_flag_b ? ~wdata : 8'h00;
    end

    pieg_flag_bank #(
        .WIDTH   (8),
        .RST_VAL (FLAG_RST)
    ) u_flags_a (
        .clk     (clk),
        .rst     (rst),
        .set_i   (set_a),
        .clr_i   (clr_a),
        .flags_o (flag_a)
    );

    pieg_flag_bank #(
        .WIDTH   (8),
        .RST_VAL (FLAG_RST)
    ) u_flags_b (
        .clk     (clk),
        .rst     (rst),
        .set_i   (set_b & ENA_B_MASK),
        .clr_i   (clr_b),
        .flags_o (flag_b8)
    );

    ////////////////////////////////////////////////////////////////////////////
    // enables, gated requests, block interrupt

    always_comb begin
        ena_a_d = wr_ena_a ? wdata : ena_a_q;
        ena_b_d = wr_ena_b ? (wdata & ENA_B_MASK) : ena_b_q;
        mask_d  = wr_mask ? (wdata & STAT_MASK) : mask_q;
        req_a_d = flag_a & ena_a_q;
        req_a_d[BIT_PARALLEL_PORT] = flag_a[BIT_PARALLEL_PORT]
                                   & ena_a_q[BIT_PARALLEL_PORT];
        req_b_d = flag_b8[3:0] & ena_b_q[3:0];
        req_b_d[BIT_TIMER_THREE] = flag_b8[BIT_TIMER_THREE]
                                 & ena_b_q[BIT_TIMER_THREE];
        req_b_d[BIT_CAPCOMP_TWO] = flag_b8[BIT_CAPCOMP_TWO]
                                 & ena_b_q[BIT_CAPCOMP_TWO];
        stat_d = stat_q & ~(wr_stat ? wdata : 8'h00);
        // set wins over write-one-to-clear
        if ((req_a_q & ~req_a_prev_q) != 8'h00) begin
            stat_d[STAT_GROUP_A] = 1'b1;
        end
        if ((req_b_q & ~req_b_prev_q) != 4'h0) begin
            stat_d[STAT_GROUP_B] = 1'b1;
        end
        case (addr)
            ENA_A_OFS:    rdata_d = ena_a_q;
            ENA_B_OFS:    rdata_d = ena_b_q;
            FLAG_A_OFS:   rdata_d = flag_a;
            FLAG_B_OFS:   rdata_d = flag_b8;
            IRQ_STAT_OFS: rdata_d = stat_q;
            IRQ_MASK_OFS: rdata_d = mask_q;
            default:      rdata_d = 8'h00;
        endcase
        if (!rd_stb) begin
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ena_a_q      <= ENA_A_RST;
            ena_b_q      <= ENA_B_RST;
            stat_q       <= IRQ_STAT_RST;
            mask_q       <= IRQ_MASK_RST;
            rdata_q      <= 8'h00;
            req_a_q      <= 8'h00;
            req_b_q      <= 4'h0;
            req_a_prev_q <= 8'h00;
            req_b_prev_q <= 4'h0;
        end else begin
            ena_a_q      <= ena_a_d;
            ena_b_q      <= ena_b_d;
            stat_q       <= stat_d;
            mask_q       <= mask_d;
            rdata_q      <= rdata_d;
            req_a_q      <= req_a_d;
            req_b_q      <= req_b_d;
            req_a_prev_q <= req_a_q;
            req_b_prev_q <= req_b_q;
        end
    end

    assign rdata = rdata_q;
    assign req_a = req_a_q;
    assign req_b = req_b_q;
    assign irq   = |(stat_q & mask_q);

endmodule // pieg_gate
`default_nettype wire

// File: core/pieg_pkg.sv
// package of register map, field positions and reset values for the enable gate
`default_nettype none
package pieg_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] ENA_A_OFS     = 4'h0;
    localparam logic [ADDR_W-1:0] ENA_B_OFS     = 4'h1;
    localparam logic [ADDR_W-1:0] FLAG_A_OFS    = 4'h2;
    localparam logic [ADDR_W-1:0] FLAG_B_OFS    = 4'h3;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS  = 4'h4;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS  = 4'h5;

    localparam logic [7:0] ENA_A_RST    = 8'h00;
    localparam logic [7:0] ENA_B_RST    = 8'h00;
    localparam logic [7:0] ENA_B_MASK   = 8'h0f;
    localparam logic [7:0] FLAG_RST     = 8'h00;
    localparam logic [7:0] IRQ_STAT_RST = 8'h00;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;

    // enable a fields
    localparam int BIT_PARALLEL_PORT = 7;
    localparam int BIT_CONVERTER     = 6;
    localparam int BIT_SERIAL_RX     = 5;
    localparam int BIT_SERIAL_TX     = 4;
    localparam int BIT_SYNC_SERIAL   = 3;
    localparam int BIT_CAPCOMP_ONE   = 2;
    localparam int BIT_PERIOD_MATCH  = 1;
    localparam int BIT_TIMER_ONE     = 0;
    // enable b fields
    localparam int BIT_BUS_COLLISION = 3;
    localparam int BIT_LOW_VOLTAGE   = 2;
    localparam int BIT_TIMER_THREE   = 1;
    localparam int BIT_CAPCOMP_TWO   = 0;

    // status/mask bits of the block's own interrupt
    localparam int STAT_GROUP_A = 0;
    localparam int STAT_GROUP_B = 1;
    localparam logic [7:0] STAT_MASK = 8'h03;

endpackage : pieg_pkg
`default_nettype wire

// File: verif/pieg_gate_sva.sv
// checker of enable gating, sticky requests and reset values of the enable gate
`timescale 1ns/1ps
`default_nettype none
module pieg_gate_chk (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] rdata,
    input wire logic       parallel_port_rd_evt,
    input wire logic       parallel_port_wr_evt,
    input wire logic [6:0] group_a_evt,
    input wire logic [3:0] group_b_evt,
    input wire logic [7:0] req_a,
    input wire logic [3:0] req_b,
    input wire logic       irq
);
    import pieg_pkg::*;
    logic [7:0] ena_a_q;
    logic [3:0] ena_b_q;
    // shadow of both enable registers, rebuilt from bus writes
    always_ff @(posedge clk) begin
        if (rst) ena_a_q <= 8'h00;
        else if (wr_stb && addr == ENA_A_OFS) ena_a_q <= wdata;
        if (rst) ena_b_q <= 4'h0;
        else if (wr_stb && addr == ENA_B_OFS) ena_b_q <= wdata[3:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    par_gate_a: assert property (req_a[7] |-> $past(ena_a_q[7]))
        else $error("parallel port request passed while disabled");
    par_share_a: assert property (($past(parallel_port_rd_evt, 2) ||
        $past(parallel_port_wr_evt, 2)) && $past(ena_a_q[7]) |-> req_a[7])
        else $error("parallel port access did not raise its request");
    tmr_gate_a: assert property (req_b[1] |-> $past(ena_b_q[1]))
        else $error("timer three request passed while disabled");
    cc_pass_a: assert property ($past(group_b_evt[0], 2) && $past(ena_b_q[0]) |-> req_b[0])
        else $error("capcomp two request not passed");
    req_sticky_a: assert property (req_b[2] && !$past(wr_stb) |=> req_b[2])
        else $error("request dropped without software action");
    req_and_a: assert property (((req_a & ~$past(ena_a_q)) |
        {4'h0, req_b & ~$past(ena_b_q)}) == 8'h00)
        else $error("request without its enable");
    rst_clear_a: assert property ($past(rst) |-> !req_a && !req_b && !irq)
        else $error("outputs not clear after reset");
endmodule // pieg_gate_chk
bind pieg_gate pieg_gate_chk i_chk (
    .clk                  (clk),
    .rst                  (rst),
    .addr                 (addr),
    .wdata                (wdata),
    .wr_stb               (wr_stb),
    .rd_stb               (rd_stb),
    .rdata                (rdata),
    .parallel_port_rd_evt (parallel_port_rd_evt),
    .parallel_port_wr_evt (parallel_port_wr_evt),
    .group_a_evt          (group_a_evt),
    .group_b_evt          (group_b_evt),
    .req_a                (req_a),
    .req_b                (req_b),
    .irq                  (irq)
);
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the enable gate
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pieg_pkg::*;
    logic       clk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, pr = 1'b0, pw = 1'b0;
    logic [3:0] addr = 4'h0, gb = 4'h0, req_b;
    logic [7:0] wdata = 8'h00, rdata, req_a;
    logic [6:0] ga = 7'h00;
    logic       irq;
    int         error_cnt = 0, checked = 0, cyc = 0;
    pieg_gate i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .parallel_port_rd_evt(pr), .parallel_port_wr_evt(pw),
        .group_a_evt(ga), .group_b_evt(gb), .req_a(req_a), .req_b(req_b), .irq(irq));
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (++cyc > 3000) begin
        error_cnt++;
        complete_run();
    end
    task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        {addr, wdata, wr_stb} <= {a, d, 1'b1};
        @(posedge clk);
        wr_stb <= 1'b0;
        settle();
    endtask
    task automatic rd(logic [3:0] a, string n, logic [7:0] exp);
        @(posedge clk);
        {addr, rd_stb} <= {a, 1'b1};
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk(n, rdata, exp);
    endtask
    task automatic ev(logic p, logic q, logic [6:0] a, logic [3:0] b);
        @(posedge clk);
        {pr, pw, ga, gb} <= {p, q, a, b};
        @(posedge clk);
        {pr, pw, ga, gb} <= 13'h0000;
        settle();
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(ENA_A_OFS, "ena_a", 8'h00);
        rd(ENA_B_OFS, "ena_b", 8'h00);
        chk("req", {req_a | {req_b, 3'h0, irq}}, 8'h00);
        $display("test reset done");
        wr(ENA_A_OFS, 8'hff);
        wr(ENA_B_OFS, 8'hff);
        rd(ENA_A_OFS, "ena_a", 8'hff);
        rd(ENA_B_OFS, "ena_b", 8'h0f);
        rd(4'hf, "unmapped", 8'h00);
        $display("test registers done");
        wr(ENA_A_OFS, 8'h7f);
        ev(1'b1, 1'b0, 7'h00, 4'h0);
        chk("req_a", req_a, 8'h00);
        rd(FLAG_A_OFS, "flag_a", 8'h80);
        wr(ENA_A_OFS, 8'hff);
        chk("req_a", req_a, 8'h80);
        wr(FLAG_A_OFS, 8'h7f);
        chk("req_a", req_a, 8'h00);
        ev(1'b0, 1'b1, 7'h7f, 4'h0);
        chk("req_a", req_a, 8'hff);
        $display("test group a done");
        wr(ENA_B_OFS, 8'h05);
        ev(1'b0, 1'b0, 7'h00, 4'hf);
        chk("req_b", {4'h0, req_b}, 8'h05);
        wr(ENA_B_OFS, 8'h0f);
        chk("req_b", {4'h0, req_b}, 8'h0f);
        rd(FLAG_B_OFS, "flag_b", 8'h0f);
        wr(FLAG_B_OFS, 8'h0d);
        chk("req_b", {4'h0, req_b}, 8'h0d);
        rd(FLAG_B_OFS, "flag_b", 8'h0d);
        $display("test group b done");
        chk("irq", {7'h00, irq}, 8'h00);
        rd(IRQ_STAT_OFS, "status", 8'h03);
        wr(IRQ_MASK_OFS, 8'h02);
        chk("irq", {7'h00, irq}, 8'h01);
        wr(IRQ_STAT_OFS, 8'h03);
        chk("irq", {7'h00, irq}, 8'h00);
        rd(IRQ_STAT_OFS, "status", 8'h00);
        $display("test interrupt done");
        complete_run();
    end
endmodule // testbench
`default_nettype wire
